// File: hw/rsp_consts.vh
// Purpose: Shared constants for the retina sensor parameter control block
// Assumes: Included by the design file by bare name
// Notes:   Register addresses are the 3-bit serial address codes
`ifndef RSP_CONSTS_VH
`define RSP_CONSTS_VH

// Serial word layout
`define RSP_WORD_BITS 11
`define RSP_ADDR_BITS 3
`define RSP_DATA_BITS 8

// Register addresses
`define RSP_ADDR_OFFS 3'h0
`define RSP_ADDR_MODE 3'h1
`define RSP_ADDR_EXPC 3'h2
`define RSP_ADDR_EXPF 3'h3
`define RSP_ADDR_KPLS 3'h4
`define RSP_ADDR_KMIN 3'h5
`define RSP_ADDR_KAUX 3'h6
`define RSP_ADDR_RAT 3'h7

// Field positions
`define RSP_VPRE_BIT 7
`define RSP_EXTR_BIT 7
`define RSP_INV_BIT 3
`define RSP_OSGN_BIT 5
`define RSP_GBST_BIT 4

// Edge direction codes
`define RSP_DIR_NONE 2'h0
`define RSP_DIR_HOR 2'h1
`define RSP_DIR_VER 2'h2
`define RSP_DIR_2D 2'h3

// Dark calibration codes
`define RSP_CAL_NONE 2'h0
`define RSP_CAL_NEG 2'h1
`define RSP_CAL_POS 2'h2

// Forced kernel values for vertical preset
`define RSP_PRE_KPLS 8'h02
`define RSP_PRE_KMIN 8'h05

// Reset values
`define RSP_RST_BYTE 8'h00

// Timing
`define RSP_FINE_STEP_NS 16000
`define RSP_COARSE_PER_FINE 256
`define RSP_CLK_NS 40
`define RSP_SENSOR_CLK_NS 2000

`endif

// File: hw/rsp_param_ctrl.v
// Purpose: Serial parameter registers, mode decode and exposure/readout
//          sequencing for a 128-column retina image sensor
// Assumes: All inputs synchronous to core_clk; the sensor clock arrives
//          as a plain input and is edge-detected here
// Notes:   Analog arithmetic is outside; this block drives its codes

`include "rsp_consts.vh"

// Operation
// RQ1 - Vertical preset forces kernels, blocks writes
// RQ2 - Decode edge direction into four modes
// RQ3 - Top ratio bit: extract high, enhance low
// RQ4 - Low ratio bits pick ascending weighting
// RQ5 - Decode dark calibration polarity codes
// RQ6 - Invert output when invert bit high
// RQ7 - Exposure equals fine plus coarse steps
// RQ8 - Zero exposure reads black offset level
// RQ9 - Host: vertical modes need exposure over 0.768ms
// RQ10 - Offset sign bit plus five magnitude bits
// RQ11 - Bias code steps half volt linearly
// RQ12 - Gain index plus boost bit adds 6dB
// RQ13 - Kernels define vertical +1/0/-1 filter
// RQ14 - Host: positive/negative typical settings
// RQ15 - Host: plus-minus filter settings
// RQ16 - Chip resets sampled on sensor clock rise
// RQ17 - Eight 8-bit registers, bits on rise
// RQ18 - Pixels output serially per sensor clock
// RQ19 - Word is 3 address then 8 data
// RQ20 - Shift while load high, commit on fall
// RQ21 - Start, expose, read out, repeat
// RQ22 - Host resets both before programming
// RQ23 - Exposure timer counts sensor clock cycles
module rsp_param_ctrl #(
    parameter NUM_COLS = 128,
    parameter NUM_ROWS = 128,
    parameter FINE_CYCLES = 8,
    parameter COARSE_STEPS = 256
)
(
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Sensor-side pins from the host controller
    input wire sensor_clk,
    input wire system_reset_n,
    input wire param_reset_n,
    input wire serial_param_in,
    input wire param_load_strobe,
    input wire start,
    // Readout timing
    output reg readout_active,
    output reg pixel_strobe,
    output reg [6:0] pixel_col,
    output reg [6:0] pixel_row,
    output reg black_level_out,
    // Decoded edge mode
    output reg [1:0] edge_direction_sel,
    output reg extract_select_bit,
    output reg [2:0] edge_ratio_sel,
    output reg vertical_preset_en,
    // Analog tuning codes
    output reg [1:0] dark_cal_sel,
    output reg invert_out,
    output reg offset_sign,
    output reg [4:0] offset_mag,
    output reg [2:0] bias_level_sel,
    output reg [3:0] gain_index,
    output reg gain_boost_bit,
    // Kernel weights
    output reg [7:0] kernel_plus,
    output reg [7:0] kernel_minus,
    output reg [7:0] kernel_aux
);

    ////////////////////////////////////////////////////////////////////
    // Sequencer states
    localparam ST_IDLE = 2'h0;
    localparam ST_EXPOSE = 2'h1;
    localparam ST_READ = 2'h2;

    ////////////////////////////////////////////////////////////////////
    // Sensor clock edge detection
    reg sclk_d_r; // Previous sensor clock sample
    wire sclk_rise; // One core cycle at each rising edge
    wire sclk_fall; // One core cycle at each falling edge

    assign sclk_rise = sensor_clk & ~sclk_d_r;
    assign sclk_fall = ~sensor_clk & sclk_d_r;

    // Sample the sensor clock once per core cycle
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            sclk_d_r <= 1'b0;
        else
            sclk_d_r <= sensor_clk;
    end

    ////////////////////////////////////////////////////////////////////
    // Chip resets, taken only on sensor clock rise
    reg sysr_r; // Registered system reset, active high
    reg parr_r; // Registered parameter reset, active high

    // Resets act at the sensor edge, not asynchronously to it
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sysr_r <= 1'b1;
            parr_r <= 1'b1;
        end
        else if (sclk_rise)
        begin
            sysr_r <= ~system_reset_n; // [RQ16]
            parr_r <= ~param_reset_n; // [RQ16]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Serial parameter shifter
    reg [`RSP_WORD_BITS-1:0] shift_r; // Incoming word, newest bit at 0
    reg [3:0] bit_cnt_r; // Bits captured in current word
    reg commit_r; // Full word waits for falling edge

    // Shift while load is high; a full word commits on next fall
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            shift_r <= {`RSP_WORD_BITS{1'b0}};
            bit_cnt_r <= 4'h0;
            commit_r <= 1'b0;
        end
        else if (parr_r)
        begin
            bit_cnt_r <= 4'h0;
            commit_r <= 1'b0;
        end
        else if (sclk_rise)
        begin
            if (param_load_strobe)
            begin
                // Address arrives first, so it ends up on top
                shift_r <= {shift_r[`RSP_WORD_BITS-2:0],
                    serial_param_in}; // [RQ17] [RQ19] [RQ20]
                if (bit_cnt_r == 4'hA)
                begin
                    bit_cnt_r <= 4'h0;
                    commit_r <= 1'b1; // [RQ19]
                end
                else
                    bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            else
                bit_cnt_r <= 4'h0; // Short word is dropped
        end
        else if (sclk_fall)
            commit_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Parameter register file, eight bytes
    reg [7:0] regs_r [0:7]; // Indexed by serial address
    wire [2:0] waddr; // Address field of the word
    wire [7:0] wdata; // Data field of the word
    wire wr_en; // Commit strobe

    assign waddr = shift_r[10:8];
    assign wdata = shift_r[7:0];
    assign wr_en = commit_r & sclk_fall;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_reg
            // Each byte loads at the falling edge after its last bit; kernel bytes 4 and 5 are held while preset is set
            always @(posedge core_clk or posedge sys_rst)
            begin
                if (sys_rst)
                    regs_r[gi] <= `RSP_RST_BYTE;
                else if (parr_r)
                    regs_r[gi] <= `RSP_RST_BYTE;
                else if (wr_en && waddr == gi &&
                    !(regs_r[`RSP_ADDR_MODE][`RSP_VPRE_BIT] &&
                    (gi == `RSP_ADDR_KPLS || gi == `RSP_ADDR_KMIN)))
                    regs_r[gi] <= wdata; // [RQ1] [RQ17] [RQ20]
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Field decode, registered straight to outputs
    wire vpre; // Vertical preset from mode register
    assign vpre = regs_r[`RSP_ADDR_MODE][`RSP_VPRE_BIT];

    // Outputs follow the register file one core cycle later
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            vertical_preset_en <= 1'b0;
            edge_direction_sel <= 2'h0;
            extract_select_bit <= 1'b0;
            edge_ratio_sel <= 3'h0;
            dark_cal_sel <= 2'h0;
            invert_out <= 1'b0;
            offset_sign <= 1'b0;
            offset_mag <= 5'h00;
            bias_level_sel <= 3'h0;
            gain_index <= 4'h0;
            gain_boost_bit <= 1'b0;
            kernel_plus <= 8'h00;
            kernel_minus <= 8'h00;
            kernel_aux <= 8'h00;
        end
        else
        begin
            vertical_preset_en <= vpre;
            // 00 none, 01 horizontal, 10 vertical, 11 two-D
            edge_direction_sel <= regs_r[`RSP_ADDR_MODE][6:5]; // [RQ2]
            // High extracts, low enhances
            extract_select_bit <=
                regs_r[`RSP_ADDR_RAT][`RSP_EXTR_BIT]; // [RQ3]
            // 50,75,100,125,200,300,400,500 percent by code
            edge_ratio_sel <= regs_r[`RSP_ADDR_RAT][6:4]; // [RQ4]
            // 10 positive, 01 negative, 00 off; 11 passed as is
            dark_cal_sel <= regs_r[`RSP_ADDR_OFFS][7:6]; // [RQ5]
            invert_out <= regs_r[`RSP_ADDR_RAT][`RSP_INV_BIT]; // [RQ6]
            offset_sign <=
                regs_r[`RSP_ADDR_OFFS][`RSP_OSGN_BIT]; // [RQ10]
            offset_mag <= regs_r[`RSP_ADDR_OFFS][4:0]; // [RQ10]
            // Half-volt steps from code 0 to 7
            bias_level_sel <= regs_r[`RSP_ADDR_RAT][2:0]; // [RQ11]
            gain_index <= regs_r[`RSP_ADDR_MODE][3:0]; // [RQ12]
            gain_boost_bit <=
                regs_r[`RSP_ADDR_MODE][`RSP_GBST_BIT]; // [RQ12]
            // Preset overrides kernels; stored bytes return once it clears
            if (vpre)
            begin
                kernel_plus <= `RSP_PRE_KPLS; // [RQ1]
                kernel_minus <= `RSP_PRE_KMIN; // [RQ1]
            end
            else
            begin
                kernel_plus <= regs_r[`RSP_ADDR_KPLS]; // [RQ13]
                kernel_minus <= regs_r[`RSP_ADDR_KMIN]; // [RQ13]
            end
            kernel_aux <= regs_r[`RSP_ADDR_KAUX];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Exposure and readout sequencer
    reg [1:0] state_r; // Sequencer state
    reg [1:0] state_nxt; // Next state
    reg [15:0] step_cnt_r; // Fine steps still to expose
    reg [3:0] sub_cnt_r; // Sensor cycles inside one fine step
    reg [6:0] col_r; // Column being read
    reg [6:0] row_r; // Row being read
    reg zero_exp_r; // Latched zero-exposure flag for this frame
    wire [15:0] total_steps; // Fine plus coarse in fine units
    wire last_pix; // Last pixel of the frame

    // Coarse step is 256 fine steps, so sum in fine units
    assign total_steps = {8'h00, regs_r[`RSP_ADDR_EXPF]} +
        {regs_r[`RSP_ADDR_EXPC], 8'h00}; // [RQ7]
    assign last_pix = (col_r == NUM_COLS - 1) && (row_r == NUM_ROWS - 1);

    // Next state
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (start)
                    state_nxt = ST_EXPOSE; // [RQ21]
            ST_EXPOSE:
                if (step_cnt_r == 16'h0000)
                    state_nxt = ST_READ;
            ST_READ:
                if (last_pix)
                    state_nxt = ST_EXPOSE; // Repeats until reset [RQ21]
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // Sequencer steps only on sensor clock rise
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r <= ST_IDLE;
            step_cnt_r <= 16'h0000;
            sub_cnt_r <= 4'h0;
            col_r <= 7'h00;
            row_r <= 7'h00;
            zero_exp_r <= 1'b0;
        end
        else if (sysr_r)
        begin
            state_r <= ST_IDLE;
            step_cnt_r <= 16'h0000;
            sub_cnt_r <= 4'h0;
            col_r <= 7'h00;
            row_r <= 7'h00;
            zero_exp_r <= 1'b0;
        end
        else if (sclk_rise)
        begin
            state_r <= state_nxt;
            if (state_nxt == ST_EXPOSE && state_r != ST_EXPOSE)
            begin
                // Load timer; zero exposure gives black readout
                step_cnt_r <= total_steps;
                sub_cnt_r <= 4'h0;
                zero_exp_r <= (total_steps == 16'h0000); // [RQ8]
            end
            else if (state_r == ST_EXPOSE && step_cnt_r != 16'h0000)
            begin
                // Count sensor cycles per fine step
                if (sub_cnt_r == FINE_CYCLES - 1)
                begin
                    sub_cnt_r <= 4'h0;
                    step_cnt_r <= step_cnt_r - 16'h0001; // [RQ23]
                end
                else
                    sub_cnt_r <= sub_cnt_r + 4'h1; // [RQ23]
            end
            if (state_r == ST_READ)
            begin
                // One pixel per sensor clock, row by row
                if (col_r == NUM_COLS - 1)
                begin
                    col_r <= 7'h00;
                    row_r <= (row_r == NUM_ROWS - 1) ? 7'h00 :
                        row_r + 7'h01; // [RQ18]
                end
                else
                    col_r <= col_r + 7'h01; // [RQ18]
            end
        end
    end

    // Readout pins, registered
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            readout_active <= 1'b0;
            pixel_strobe <= 1'b0;
            pixel_col <= 7'h00;
            pixel_row <= 7'h00;
            black_level_out <= 1'b0;
        end
        else
        begin
            // Same format at zero exposure; only the level differs
            readout_active <= (state_r == ST_READ); // [RQ8] [RQ21]
            pixel_strobe <= sclk_rise && (state_r == ST_READ); // [RQ18]
            pixel_col <= col_r;
            pixel_row <= row_r;
            black_level_out <= zero_exp_r && (state_r == ST_READ); // [RQ8]
        end
    end

endmodule

// File: verif/rsp_param_ctrl_props.sv
// Purpose: Port-level checks for the parameter control block
// Assumes: Each sensor clock phase lasts at least 4 core cycles
// Notes:   Bound to every instance of rsp_param_ctrl
module rsp_param_ctrl_props #(
    parameter NUM_COLS = 128,
    parameter NUM_ROWS = 128
)
(
    // Clock and reset
    input logic core_clk,
    input logic sys_rst,
    // Host pins
    input logic sensor_clk,
    input logic system_reset_n,
    input logic param_reset_n,
    // Readout
    input logic readout_active,
    input logic pixel_strobe,
    input logic black_level_out,
    // Decoded fields
    input logic [1:0] edge_direction_sel,
    input logic vertical_preset_en,
    input logic [7:0] kernel_plus,
    input logic [7:0] kernel_minus,
    input logic [7:0] kernel_aux
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    // Pixels counted within the current readout burst
    int pix_cnt_r;
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            pix_cnt_r <= 0;
        else if (!readout_active)
            pix_cnt_r <= 0;
        else if (pixel_strobe)
            pix_cnt_r <= pix_cnt_r + 1;
    end
    // Chip reset pin taken low and held
    sequence s_chip_reset;
        $fell(system_reset_n) ##1 !system_reset_n;
    endsequence
    ////////////////////////////////////////
    property p_preset_kern;
        vertical_preset_en && $past(vertical_preset_en)
            |-> kernel_plus == 8'h02 && kernel_minus == 8'h05;
    endproperty
    a_preset_kern: assert property (p_preset_kern)
        else $error("kernel codes not forced under preset");
    // Commits land in the low phase; a parameter clear is excluded
    property p_aux_on_fall;
        $changed(kernel_aux) && param_reset_n |-> !sensor_clk;
    endproperty
    a_aux_on_fall: assert property (p_aux_on_fall)
        else $error("kernel_aux changed outside the low phase");
    property p_dir_on_fall;
        $changed(edge_direction_sel) && param_reset_n |-> !sensor_clk;
    endproperty
    a_dir_on_fall: assert property (p_dir_on_fall)
        else $error("edge direction changed outside the low phase");
    property p_strobe_in_read;
        pixel_strobe |-> readout_active;
    endproperty
    a_strobe_in_read: assert property (p_strobe_in_read)
        else $error("pixel strobe outside readout");
    property p_strobe_pulse;
        pixel_strobe |=> !pixel_strobe;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse)
        else $error("pixel strobe longer than one cycle");
    property p_strobe_rise;
        $rose(pixel_strobe) |-> sensor_clk;
    endproperty
    a_strobe_rise: assert property (p_strobe_rise)
        else $error("pixel strobe not tied to a sensor rise");
    property p_black_read;
        black_level_out |-> readout_active;
    endproperty
    a_black_read: assert property (p_black_read)
        else $error("black level flag outside readout");
    property p_read_len;
        $fell(readout_active) && system_reset_n
            |-> pix_cnt_r == NUM_COLS * NUM_ROWS;
    endproperty
    a_read_len: assert property (p_read_len)
        else $error("readout burst has wrong pixel count");
    // 24 cycles covers three sensor phases of 4 plus pipeline
    property p_chip_reset;
        s_chip_reset |-> ##[1:24] !readout_active;
    endproperty
    a_chip_reset: assert property (p_chip_reset)
        else $error("readout survived chip reset");
endmodule
bind rsp_param_ctrl rsp_param_ctrl_props #(
    .NUM_COLS(NUM_COLS),
    .NUM_ROWS(NUM_ROWS)
) u_rsp_param_ctrl_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .sensor_clk(sensor_clk),
    .system_reset_n(system_reset_n), .param_reset_n(param_reset_n),
    .readout_active(readout_active), .pixel_strobe(pixel_strobe),
    .black_level_out(black_level_out),
    .edge_direction_sel(edge_direction_sel),
    .vertical_preset_en(vertical_preset_en), .kernel_plus(kernel_plus),
    .kernel_minus(kernel_minus), .kernel_aux(kernel_aux)
);

// File: verif/rsp_host_model.sv
// Purpose: Host controller model for the sensor-side pins
// Assumes: Pins other than the sensor clock change only on core edges where it falls
// Notes:   Released data and load pins sit at their pull-down level
module rsp_host_model #(
    parameter HALF = 4
)
(
    // Core clock
    input wire logic core_clk,
    // Sensor-side pins
    output logic sensor_clk,
    output logic system_reset_n,
    output logic param_reset_n,
    output logic serial_param_in,
    output logic param_load_strobe,
    output logic start
);
    timeunit 1ns;
    timeprecision 1ps;
    int ph = 0;
    // Pulled pins at rest from time zero
    initial
    begin
        sensor_clk = 1'b0;
        system_reset_n = 1'b1;
        param_reset_n = 1'b1;
        serial_param_in = 1'b0;
        param_load_strobe = 1'b0;
        start = 1'b0;
    end
    // Free-running sensor clock, HALF core cycles per phase
    always @(posedge core_clk)
    begin
        if (ph == HALF - 1)
        begin
            ph <= 0;
            sensor_clk <= ~sensor_clk;
        end
        else
            ph <= ph + 1;
    end
    ////////////////////////////////////////
    // Wait for the core edge that drops the sensor clock
    task wait_fall;
        do @(posedge core_clk);
        while (!(ph == HALF - 1 && sensor_clk));
    endtask
    // Send the top n bits of a word, address first; a short word aborts
    task send_bits(input logic [10:0] w, input int n);
        for (int i = 0; i < n; i++)
        begin
            wait_fall();
            param_load_strobe <= 1'b1;
            serial_param_in <= w[10 - i];
        end
        wait_fall();
        param_load_strobe <= 1'b0;
        serial_param_in <= 1'b0;
    endtask
    // Chip reset across two sensor rises, optionally clearing parameters
    task pin_reset(input logic clr);
        wait_fall();
        system_reset_n <= 1'b0;
        param_reset_n <= ~clr;
        wait_fall();
        wait_fall();
        system_reset_n <= 1'b1;
        param_reset_n <= 1'b1;
        wait_fall();
    endtask
    // Start held high across exactly one sensor rise
    task start_pulse;
        wait_fall();
        start <= 1'b1;
        wait_fall();
        start <= 1'b0;
    endtask
endmodule

// File: verif/testbench.sv
// Purpose: Self-checking bench for the parameter control block
// Assumes: Host model paces all sensor-side pins
// Notes:   Small array and 8-core-cycle sensor period keep runs short
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 4;
    localparam int PER = 2 * HALF;
    localparam int COLS = 4;
    localparam int ROWS = 4;
    localparam int FINE = 8;
    localparam int LIMIT = 80000;
    logic core_clk;
    logic sys_rst;
    wire sensor_clk, system_reset_n, param_reset_n;
    wire serial_param_in, param_load_strobe, start;
    wire readout_active, pixel_strobe, black_level_out;
    wire [6:0] pixel_col, pixel_row;
    wire [1:0] edge_direction_sel, dark_cal_sel;
    wire extract_select_bit, vertical_preset_en, invert_out;
    wire offset_sign, gain_boost_bit;
    wire [2:0] edge_ratio_sel, bias_level_sel;
    wire [4:0] offset_mag;
    wire [3:0] gain_index;
    wire [7:0] kernel_plus, kernel_minus, kernel_aux;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    rsp_host_model #(.HALF(HALF)) u_rsp_host_model (
        .core_clk(core_clk), .sensor_clk(sensor_clk),
        .system_reset_n(system_reset_n), .param_reset_n(param_reset_n),
        .serial_param_in(serial_param_in),
        .param_load_strobe(param_load_strobe), .start(start));
    rsp_param_ctrl #(.NUM_COLS(COLS), .NUM_ROWS(ROWS),
        .FINE_CYCLES(FINE), .COARSE_STEPS(256)) u_rsp_param_ctrl (
        .core_clk(core_clk), .sys_rst(sys_rst), .sensor_clk(sensor_clk),
        .system_reset_n(system_reset_n), .param_reset_n(param_reset_n),
        .serial_param_in(serial_param_in),
        .param_load_strobe(param_load_strobe), .start(start),
        .readout_active(readout_active), .pixel_strobe(pixel_strobe),
        .pixel_col(pixel_col), .pixel_row(pixel_row),
        .black_level_out(black_level_out),
        .edge_direction_sel(edge_direction_sel),
        .extract_select_bit(extract_select_bit),
        .edge_ratio_sel(edge_ratio_sel),
        .vertical_preset_en(vertical_preset_en),
        .dark_cal_sel(dark_cal_sel), .invert_out(invert_out),
        .offset_sign(offset_sign), .offset_mag(offset_mag),
        .bias_level_sel(bias_level_sel), .gain_index(gain_index),
        .gain_boost_bit(gain_boost_bit), .kernel_plus(kernel_plus),
        .kernel_minus(kernel_minus), .kernel_aux(kernel_aux));
    ////////////////////////////////////////
    // 25 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Hang guard: a run past LIMIT cycles is a failure
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            error_cnt++;
            print_verdict();
        end
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // One full word, then let commit and output stage settle
    task wr(input logic [2:0] a, input logic [7:0] d);
        u_rsp_host_model.send_bits({a, d}, 11);
        repeat (4) @(posedge core_clk);
    endtask
    // Program exposure, start, time the exposure, then walk the readout
    task frame(input logic [7:0] crs, input logic [7:0] fin, input logic blk);
        int w;
        int n;
        int e;
        e = (fin + 256 * crs) * FINE * PER;
        u_rsp_host_model.pin_reset(1'b1);
        chk(readout_active, 1'b0);
        wr(3'h2, crs);
        wr(3'h3, fin);
        // Vertical mode only with exposures well above 48 fine steps
        if (crs != 8'h00)
            wr(3'h1, 8'h40);
        u_rsp_host_model.start_pulse();
        w = 0;
        while (readout_active !== 1'b1 && w < 20000)
        begin
            @(posedge core_clk);
            w++;
        end
        chk(w + PER >= e && w <= e + PER, 1'b1);
        n = 0;
        w = 0;
        while (readout_active === 1'b1 && w < 400)
        begin
            if (pixel_strobe === 1'b1 && n == 0)
            begin
                chk(pixel_col, 8'h00);
                chk(pixel_row, 8'h00);
                chk(black_level_out, blk);
            end
            if (pixel_strobe === 1'b1 && n == COLS * ROWS - 1)
            begin
                chk(pixel_col, 8'(COLS - 1));
                chk(pixel_row, 8'(ROWS - 1));
            end
            n += (pixel_strobe === 1'b1);
            @(posedge core_clk);
            w++;
        end
        chk(8'(n), 8'(COLS * ROWS));
        if (crs == 8'h00 && !blk)
        begin
            w = 0;
            while (readout_active !== 1'b1 && w < 400)
            begin
                @(posedge core_clk);
                w++;
            end
            chk(readout_active, 1'b1);
        end
    endtask
    ////////////////////////////////////////
    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        chk(kernel_plus, 8'h00);
        u_rsp_host_model.pin_reset(1'b1);
        for (int k = 0; k < 4; k++)
        begin
            wr(3'h1, {1'b0, k[1:0], ~k[0], ~k[3:0]});
            chk(edge_direction_sel, k[1:0]);
            chk(gain_index, {~k[3:0]});
            chk(gain_boost_bit, {~k[0]});
            wr(3'h0, {k[1:0], ~k[0], 5'h1F ^ k[4:0]});
            chk(dark_cal_sel, k[1:0]);
            chk(offset_sign, {~k[0]});
            chk(offset_mag, 5'h1F ^ k[4:0]);
        end
        for (int k = 0; k < 16; k++)
        begin
            wr(3'h7, {k[3:0], ~k[0], k[2:0]});
            chk(extract_select_bit, k[3]);
            chk(edge_ratio_sel, k[2:0]);
            chk(invert_out, {~k[0]});
            chk(bias_level_sel, k[2:0]);
        end
        wr(3'h4, 8'h01);
        wr(3'h5, 8'h02);
        wr(3'h6, 8'h01);
        chk(kernel_plus, 8'h01);
        chk(kernel_minus, 8'h02);
        wr(3'h1, 8'hC0);
        chk(vertical_preset_en, 8'h01);
        chk(kernel_plus, 8'h02);
        chk(kernel_minus, 8'h05);
        wr(3'h4, 8'hAA);
        chk(kernel_plus, 8'h02);
        wr(3'h1, 8'h40);
        chk(kernel_plus, 8'h01);
        // Typical positive image settings
        wr(3'h5, 8'h00);
        wr(3'h0, 8'h80);
        chk(kernel_minus, 8'h00);
        chk(kernel_aux, 8'h01);
        chk(dark_cal_sel, 8'h02);
        // Typical negative image settings
        wr(3'h4, 8'h00);
        wr(3'h5, 8'h01);
        wr(3'h0, 8'h40);
        wr(3'h7, 8'h08);
        chk(kernel_plus, 8'h00);
        chk(kernel_minus, 8'h01);
        chk(dark_cal_sel, 8'h01);
        chk(invert_out, 8'h01);
        u_rsp_host_model.send_bits({3'h6, 8'hFF}, 5);
        wr(3'h6, 8'h3C);
        chk(kernel_aux, 8'h3C);
        u_rsp_host_model.pin_reset(1'b1);
        chk(kernel_aux, 8'h00);
        frame(8'h00, 8'h02, 1'b0);
        frame(8'h01, 8'h02, 1'b0);
        frame(8'h00, 8'h00, 1'b1);
        print_verdict();
    end
endmodule
